// ===== rtl/hdps_loss_timer.sv
// loss-of-signal timeout on one reference input
`default_nettype none

module hdps_loss_timer (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       check_on,
	input  wire logic       ref_is_mos,
	input  wire logic [1:0] window,
	input  wire logic       activity,
	output logic            loss,
	output logic            switch_evt
);

	hdps_pkg::hdps_loss_e state_reg, state_next;
	logic [7:0]           count_reg, count_next;
	logic                 evt_reg, evt_next;

	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		evt_next   = 1'b0;
		if (!(check_on && ref_is_mos)) begin // R6
			state_next = hdps_pkg::HDPS_REF_OK;
			count_next = 8'h00;
		end else if (activity) begin
			state_next = hdps_pkg::HDPS_REF_OK;
			count_next = 8'h00;
		end else begin
			case (state_reg)
				hdps_pkg::HDPS_REF_OK: begin
					count_next = count_reg + 8'h01;
					if (count_next >= hdps_pkg::loss_limit(window)) begin // R5
						state_next = hdps_pkg::HDPS_REF_LOST;
						evt_next   = 1'b1;
					end
				end
				hdps_pkg::HDPS_REF_LOST: count_next = count_reg;
				default: state_next = hdps_pkg::HDPS_REF_OK;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= hdps_pkg::HDPS_REF_OK;
			count_reg <= 8'h00;
			evt_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			evt_reg   <= evt_next;
		end
	end

	assign loss       = (state_reg == hdps_pkg::HDPS_REF_LOST);
	assign switch_evt = evt_reg;

endmodule

`default_nettype wire

// ===== rtl/hdps_pin_ctrl.sv
// multipurpose reset pin: reset input or status output
`default_nettype none

module hdps_pin_ctrl (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [2:0] io_type,
	input  wire logic [2:0] status_sel,
	input  wire logic       pin_level,
	input  wire logic       ref_two_sel,
	input  wire logic       dac_locked,
	input  wire logic       dac_low,
	input  wire logic       dac_high,
	input  wire logic       readback,
	output logic            pin_o,
	output logic            pin_oe,
	output logic            pull_up,
	output logic            pull_dn,
	output logic            pin_reset
);

	logic o_reg, o_next;
	logic oe_reg, oe_next;
	logic pu_reg, pu_next;
	logic pd_reg, pd_next;
	logic rst_reg, rst_next;
	logic value;

	always_comb begin
		case (status_sel) // R1
			hdps_pkg::SEL_LOW:     value = 1'b0;
			hdps_pkg::SEL_REF_TWO: value = ref_two_sel;
			hdps_pkg::SEL_LOCKED:  value = dac_locked;
			hdps_pkg::SEL_DAC_LOW: value = dac_low;
			hdps_pkg::SEL_DAC_HI:  value = dac_high;
			hdps_pkg::SEL_RDBK:    value = readback;
			default:               value = 1'b0; // R15
		endcase
		o_next   = 1'b0;
		oe_next  = 1'b0;
		pu_next  = (io_type == hdps_pkg::IO_IN_PU); // R3
		pd_next  = (io_type == hdps_pkg::IO_IN_PD); // R3
		rst_next = hdps_pkg::is_input_type(io_type) && pin_level; // R4
		// the selection only reaches the pin in output types
		case (io_type) // R2
			hdps_pkg::IO_PP: begin
				o_next  = value;
				oe_next = 1'b1;
			end
			hdps_pkg::IO_PP_INV: begin
				o_next  = ~value;
				oe_next = 1'b1;
			end
			hdps_pkg::IO_OD: begin
				o_next  = 1'b0;
				oe_next = ~value;
			end
			default: begin
				o_next  = 1'b0;
				oe_next = 1'b0; // R15
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			o_reg   <= 1'b0;
			oe_reg  <= 1'b0;
			pu_reg  <= 1'b0;
			pd_reg  <= 1'b1;
			rst_reg <= 1'b0;
		end else begin
			o_reg   <= o_next;
			oe_reg  <= oe_next;
			pu_reg  <= pu_next;
			pd_reg  <= pd_next;
			rst_reg <= rst_next;
		end
	end

	assign pin_o     = o_reg;
	assign pin_oe    = oe_reg;
	assign pull_up   = pu_reg;
	assign pull_dn   = pd_reg;
	assign pin_reset = rst_reg;

endmodule

`default_nettype wire

// ===== rtl/hdps_pkg.sv
// shared constants and types for the holdover dac and pin status control
`default_nettype none

package hdps_pkg;

	// ------------------------------------------------------------
	// register addresses
	// ------------------------------------------------------------
	localparam logic [8:0] PIN_CFG_ADDR   = 9'h14A;
	localparam logic [8:0] HOLD_CTRL_ADDR = 9'h14B;
	localparam logic [8:0] FIXED_LO_ADDR  = 9'h14C;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int PIN_SEL_LSB   = 3;
	localparam int PIN_SEL_MSB   = 5;
	localparam int IO_TYPE_LSB   = 0;
	localparam int IO_TYPE_MSB   = 2;
	localparam int LOSS_WIN_LSB  = 6;
	localparam int LOSS_WIN_MSB  = 7;
	localparam int LOSS_ON_BIT   = 5;
	localparam int FOLLOW_BIT    = 4;
	localparam int FORCE_BIT     = 3;
	localparam int FIX_SEL_BIT   = 2;
	localparam int FIX_HI_LSB    = 0;
	localparam int FIX_HI_MSB    = 1;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [2:0] PIN_SEL_RST  = 3'h0;
	localparam logic [2:0] IO_TYPE_RST  = 3'h2;
	localparam logic [1:0] LOSS_WIN_RST = 2'h0;
	localparam logic       LOSS_ON_RST  = 1'h0;
	localparam logic       FOLLOW_RST   = 1'h1;
	localparam logic       FORCE_RST    = 1'h0;
	localparam logic       FIX_SEL_RST  = 1'h1;
	localparam logic [1:0] FIX_HI_RST   = 2'h2;
	localparam logic [7:0] FIX_LO_RST   = 8'h00;
	localparam logic [9:0] TRACK_MID    = 10'h200;
	localparam logic [1:0] PIN_MASK_CYC = 2'h3;

	// ------------------------------------------------------------
	// pin io types and status selections
	// ------------------------------------------------------------
	localparam logic [2:0] IO_IN       = 3'h0;
	localparam logic [2:0] IO_IN_PU    = 3'h1;
	localparam logic [2:0] IO_IN_PD    = 3'h2;
	localparam logic [2:0] IO_PP       = 3'h3;
	localparam logic [2:0] IO_PP_INV   = 3'h4;
	localparam logic [2:0] IO_OD       = 3'h6;
	localparam logic [2:0] SEL_LOW     = 3'h0;
	localparam logic [2:0] SEL_REF_TWO = 3'h2;
	localparam logic [2:0] SEL_LOCKED  = 3'h3;
	localparam logic [2:0] SEL_DAC_LOW = 3'h4;
	localparam logic [2:0] SEL_DAC_HI  = 3'h5;
	localparam logic [2:0] SEL_RDBK    = 3'h6;

	// ------------------------------------------------------------
	// signal loss windows, least time so rounded up
	// ------------------------------------------------------------
	localparam int CLK_HZ      = 25000000;
	localparam int LOSS_F0_HZ  = 370000;
	localparam int LOSS_F1_HZ  = 2100000;
	localparam int LOSS_F2_HZ  = 8800000;
	localparam int LOSS_F3_HZ  = 22000000;
	localparam logic [7:0] LOSS_CYC0 =
		8'((CLK_HZ + LOSS_F0_HZ - 1) / LOSS_F0_HZ);
	localparam logic [7:0] LOSS_CYC1 =
		8'((CLK_HZ + LOSS_F1_HZ - 1) / LOSS_F1_HZ);
	localparam logic [7:0] LOSS_CYC2 =
		8'((CLK_HZ + LOSS_F2_HZ - 1) / LOSS_F2_HZ);
	localparam logic [7:0] LOSS_CYC3 =
		8'((CLK_HZ + LOSS_F3_HZ - 1) / LOSS_F3_HZ);

	typedef enum logic [1:0] {
		HDPS_REF_OK   = 2'b01,
		HDPS_REF_LOST = 2'b10
	} hdps_loss_e;

	function automatic logic is_input_type(input logic [2:0] t);
		is_input_type = (t == IO_IN) || (t == IO_IN_PU) || (t == IO_IN_PD);
	endfunction

	function automatic logic [7:0] loss_limit(input logic [1:0] w);
		case (w)
			2'h0: loss_limit = LOSS_CYC0;
			2'h1: loss_limit = LOSS_CYC1;
			2'h2: loss_limit = LOSS_CYC2;
			default: loss_limit = LOSS_CYC3;
		endcase
	endfunction

endpackage

`default_nettype wire

// ===== rtl/hdps_top.sv
// holdover dac and multipurpose pin control, top level
//
// Overview of operation
// R1 - status select: 0 low, 2 ref two, 3 lock, 4 low, 5 high, 6 readback
// R2 - status select has no effect unless the io type is an output type
// R3 - io type in, pull-up, pull-down, push-pull, inverse, open-drain; reset 2
// R4 - in any input type a high pin holds the device in reset
// R5 - loss window codes 0..3 give 370 kHz, 2.1, 8.8, 22 MHz timeouts
// R6 - signal loss check bit enables the timeout, only for mos inputs
// R7 - follow bit lets the dac track the first loop, only while locked
// R8 - after reset the tracked dac code starts at 512
// R9 - tracking runs whatever the operating mode
// R10 - hold forced bit puts the device in holdover regardless of references
// R11 - forced holdover gives fixed value if selected, else latest tracked
// R12 - fixed dac select: 0 tracked, 1 programmed value; reset 1
// R13 - holdover control bits 1:0 are fixed value upper bits; reset 2
// R14 - fixed value lower byte lives at the next address; 10-bit code
// R15 - reserved bits read zero; reserved codes give no defined behaviour
`default_nettype none

module hdps_top (
	input  wire logic       CORE_CLK,
	input  wire logic       RESET_N,
	input  wire logic [8:0] REG_ADDR,
	input  wire logic [7:0] REG_WDATA,
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	output logic      [7:0] REG_RDATA,
	output logic            REG_RVALID,
	input  wire logic       RST_PIN_I,
	output logic            RST_PIN_O,
	output logic            RST_PIN_OE,
	output logic            RST_PIN_PULL_UP,
	output logic            RST_PIN_PULL_DN,
	output logic            PIN_RESET,
	input  wire logic       REF_TWO_SELECTED,
	input  wire logic       DAC_LOCKED,
	input  wire logic       DAC_LOW,
	input  wire logic       DAC_HIGH,
	input  wire logic       READBACK_DATA,
	input  wire logic       REF_CLK_IN,
	input  wire logic       REF_IS_MOS,
	output logic            SIGNAL_LOSS,
	output logic            CLK_SWITCH_EVT,
	input  wire logic       FIRST_LOOP_LOCKED,
	input  wire logic [9:0] TUNE_CODE,
	input  wire logic       TRACK_TICK,
	input  wire logic       AUTO_HOLD,
	output logic            HOLDOVER_ACTIVE,
	output logic      [9:0] TRACKED_CODE,
	output logic      [9:0] DAC_CODE
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic pin_s1_reg, pin_s2_reg;
	logic ref_s1_reg, ref_s2_reg, ref_s3_reg;
	logic ref_edge;

	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			pin_s1_reg <= 1'b0;
			pin_s2_reg <= 1'b0;
			ref_s1_reg <= 1'b0;
			ref_s2_reg <= 1'b0;
			ref_s3_reg <= 1'b0;
		end else begin
			pin_s1_reg <= RST_PIN_I;
			pin_s2_reg <= pin_s1_reg;
			ref_s1_reg <= REF_CLK_IN;
			ref_s2_reg <= ref_s1_reg;
			ref_s3_reg <= ref_s2_reg;
		end
	end

	// any transition on the reference counts as activity
	assign ref_edge = ref_s2_reg ^ ref_s3_reg;

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	logic [2:0] pin_sel_reg, pin_sel_next;
	logic [2:0] io_type_reg, io_type_next;
	logic [1:0] loss_win_reg, loss_win_next;
	logic       loss_on_reg, loss_on_next;
	logic       follow_reg, follow_next;
	logic       force_reg, force_next;
	logic       fix_sel_reg, fix_sel_next;
	logic [1:0] fix_hi_reg, fix_hi_next;
	logic [7:0] fix_lo_reg, fix_lo_next;

	always_comb begin
		pin_sel_next  = pin_sel_reg;
		io_type_next  = io_type_reg;
		loss_win_next = loss_win_reg;
		loss_on_next  = loss_on_reg;
		follow_next   = follow_reg;
		force_next    = force_reg;
		fix_sel_next  = fix_sel_reg;
		fix_hi_next   = fix_hi_reg;
		fix_lo_next   = fix_lo_reg;
		if (REG_WR) begin
			case (REG_ADDR)
				hdps_pkg::PIN_CFG_ADDR: begin
					// bits 7:6 are not stored
					pin_sel_next = REG_WDATA[hdps_pkg::PIN_SEL_MSB:
						hdps_pkg::PIN_SEL_LSB]; // R1
					io_type_next = REG_WDATA[hdps_pkg::IO_TYPE_MSB:
						hdps_pkg::IO_TYPE_LSB]; // R3
				end
				hdps_pkg::HOLD_CTRL_ADDR: begin
					loss_win_next = REG_WDATA[hdps_pkg::LOSS_WIN_MSB:
						hdps_pkg::LOSS_WIN_LSB]; // R5
					loss_on_next  = REG_WDATA[hdps_pkg::LOSS_ON_BIT]; // R6
					follow_next   = REG_WDATA[hdps_pkg::FOLLOW_BIT]; // R7
					force_next    = REG_WDATA[hdps_pkg::FORCE_BIT]; // R10
					fix_sel_next  = REG_WDATA[hdps_pkg::FIX_SEL_BIT]; // R12
					fix_hi_next   = REG_WDATA[hdps_pkg::FIX_HI_MSB:
						hdps_pkg::FIX_HI_LSB]; // R13
				end
				hdps_pkg::FIXED_LO_ADDR: begin
					fix_lo_next = REG_WDATA; // R14
				end
				default: begin
					fix_lo_next = fix_lo_reg;
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			pin_sel_reg  <= hdps_pkg::PIN_SEL_RST;
			io_type_reg  <= hdps_pkg::IO_TYPE_RST;
			loss_win_reg <= hdps_pkg::LOSS_WIN_RST;
			loss_on_reg  <= hdps_pkg::LOSS_ON_RST;
			follow_reg   <= hdps_pkg::FOLLOW_RST;
			force_reg    <= hdps_pkg::FORCE_RST;
			fix_sel_reg  <= hdps_pkg::FIX_SEL_RST;
			fix_hi_reg   <= hdps_pkg::FIX_HI_RST;
			fix_lo_reg   <= hdps_pkg::FIX_LO_RST;
		end else begin
			pin_sel_reg  <= pin_sel_next;
			io_type_reg  <= io_type_next;
			loss_win_reg <= loss_win_next;
			loss_on_reg  <= loss_on_next;
			follow_reg   <= follow_next;
			force_reg    <= force_next;
			fix_sel_reg  <= fix_sel_next;
			fix_hi_reg   <= fix_hi_next;
			fix_lo_reg   <= fix_lo_next;
		end
	end

	// ------------------------------------------------------------
	// register readback
	// ------------------------------------------------------------
	logic [7:0] rdata_reg, rdata_next;
	logic       rvalid_reg, rvalid_next;

	always_comb begin
		rdata_next  = rdata_reg;
		rvalid_next = REG_RD;
		if (REG_RD) begin
			case (REG_ADDR)
				hdps_pkg::PIN_CFG_ADDR: begin
					rdata_next = {2'h0, pin_sel_reg, io_type_reg}; // R15
				end
				hdps_pkg::HOLD_CTRL_ADDR: begin
					rdata_next = {loss_win_reg, loss_on_reg, follow_reg,
						force_reg, fix_sel_reg, fix_hi_reg};
				end
				hdps_pkg::FIXED_LO_ADDR: begin
					rdata_next = fix_lo_reg;
				end
				default: begin
					rdata_next = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			rdata_reg  <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg  <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	assign REG_RDATA  = rdata_reg;
	assign REG_RVALID = rvalid_reg;

	// ------------------------------------------------------------
	// dac tracking and holdover output
	// ------------------------------------------------------------
	logic [9:0] track_reg, track_next;
	logic [9:0] dac_reg, dac_next;
	logic       hold_reg, hold_next;
	logic [9:0] fixed_code;
	logic       pin_reset;

	assign fixed_code = {fix_hi_reg, fix_lo_reg}; // R14

	always_comb begin
		track_next = track_reg;
		// no dependence on holdover state or mode
		if (pin_reset) begin
			track_next = hdps_pkg::TRACK_MID; // R8
		end else if (follow_reg && FIRST_LOOP_LOCKED && TRACK_TICK) begin
			track_next = TUNE_CODE; // R7 R9
		end
		hold_next = force_reg || AUTO_HOLD; // R10
		if (hold_reg && fix_sel_reg) begin
			dac_next = fixed_code; // R11 R12
		end else begin
			dac_next = track_reg; // R11
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			track_reg <= hdps_pkg::TRACK_MID; // R8
			dac_reg   <= hdps_pkg::TRACK_MID;
			hold_reg  <= 1'b0;
		end else begin
			track_reg <= track_next;
			dac_reg   <= dac_next;
			hold_reg  <= hold_next;
		end
	end

	assign TRACKED_CODE    = track_reg;
	assign DAC_CODE        = dac_reg;
	assign HOLDOVER_ACTIVE = hold_reg;

	// ------------------------------------------------------------
	// pin reset qualification
	// ------------------------------------------------------------
	// leaving an output type, the synchroniser still holds the level
	// this block drove; the pin is not believed until that has flushed
	logic [1:0] mask_cnt_reg, mask_cnt_next;
	logic       pin_level;

	always_comb begin
		mask_cnt_next = mask_cnt_reg;
		if (!hdps_pkg::is_input_type(io_type_reg)) begin
			mask_cnt_next = hdps_pkg::PIN_MASK_CYC;
		end else if (mask_cnt_reg != 2'h0) begin
			mask_cnt_next = mask_cnt_reg - 2'h1;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			mask_cnt_reg <= 2'h0;
		end else begin
			mask_cnt_reg <= mask_cnt_next;
		end
	end

	assign pin_level = pin_s2_reg && (mask_cnt_reg == 2'h0); // R4

	// ------------------------------------------------------------
	// pin and loss timer
	// ------------------------------------------------------------
	hdps_pin_ctrl u_pin (
		.clk         (CORE_CLK),
		.rst_n       (RESET_N),
		.io_type     (io_type_reg),
		.status_sel  (pin_sel_reg),
		.pin_level   (pin_level),
		.ref_two_sel (REF_TWO_SELECTED),
		.dac_locked  (DAC_LOCKED),
		.dac_low     (DAC_LOW),
		.dac_high    (DAC_HIGH),
		.readback    (READBACK_DATA),
		.pin_o       (RST_PIN_O),
		.pin_oe      (RST_PIN_OE),
		.pull_up     (RST_PIN_PULL_UP),
		.pull_dn     (RST_PIN_PULL_DN),
		.pin_reset   (pin_reset)
	);

	assign PIN_RESET = pin_reset;

	hdps_loss_timer u_loss (
		.clk        (CORE_CLK),
		.rst_n      (RESET_N),
		.check_on   (loss_on_reg),
		.ref_is_mos (REF_IS_MOS),
		.window     (loss_win_reg),
		.activity   (ref_edge),
		.loss       (SIGNAL_LOSS),
		.switch_evt (CLK_SWITCH_EVT)
	);

endmodule

`default_nettype wire

// ===== verification/hdps_pin_board.sv
// board model that drives or senses the multipurpose reset pin
`default_nettype none

module hdps_pin_board (
	input  wire logic clk,
	input  wire logic pin_o,
	input  wire logic pin_oe,
	input  wire logic pull_up,
	input  wire logic pull_dn,
	input  wire logic drive_on,
	input  wire logic drive_val,
	output logic      pin_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_level = 1'h0;

	// a floating wire keeps changing so no stale level is seen
	always @(posedge clk) last_level <= pin_i;
	// board holds the pin low in normal use
	assign pin_i = pin_oe ? pin_o : drive_on ? drive_val :
		pull_up ? 1'h1 : pull_dn ? 1'h0 : ~last_level;
endmodule

`default_nettype wire

// ===== verification/hdps_top_chk.sv
// concurrent checks on the ports of the holdover and pin control top
`default_nettype none

module hdps_top_chk (
	input wire logic       CORE_CLK,
	input wire logic       RESET_N,
	input wire logic [8:0] REG_ADDR,
	input wire logic       REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic       REG_RVALID,
	input wire logic       RST_PIN_I,
	input wire logic       RST_PIN_OE,
	input wire logic       RST_PIN_PULL_UP,
	input wire logic       RST_PIN_PULL_DN,
	input wire logic       PIN_RESET,
	input wire logic       REF_IS_MOS,
	input wire logic       SIGNAL_LOSS,
	input wire logic       CLK_SWITCH_EVT,
	input wire logic       FIRST_LOOP_LOCKED,
	input wire logic       TRACK_TICK,
	input wire logic       AUTO_HOLD,
	input wire logic       HOLDOVER_ACTIVE,
	input wire logic [9:0] TRACKED_CODE,
	input wire logic [9:0] DAC_CODE
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);

	// ------------------------------------------------------------
	// sequences
	// ------------------------------------------------------------
	sequence rd_cfg_s;
		REG_RD && REG_ADDR == 9'h14A;
	endsequence
	sequence rd_unmapped_s;
		REG_RD && (REG_ADDR < 9'h14A || REG_ADDR > 9'h14C);
	endsequence
	sequence no_update_s;
		!(FIRST_LOOP_LOCKED && TRACK_TICK) && !PIN_RESET;
	endsequence
	sequence mos_off_s;
		!REF_IS_MOS [*2];
	endsequence

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	read_valid_a: assert property (REG_RD |=> REG_RVALID)
		else $error("read strobe gave no valid pulse");
	cfg_reserved_a: assert property (rd_cfg_s |=> REG_RDATA[7:6] == 2'h0)
		else $error("reserved config bits read nonzero");
	unmapped_zero_a: assert property (rd_unmapped_s
		|=> REG_RDATA == 8'h00)
		else $error("unmapped read returned nonzero");
	pull_exclusive_a: assert property (
		(RST_PIN_PULL_UP || RST_PIN_PULL_DN)
		|-> !RST_PIN_OE && !(RST_PIN_PULL_UP && RST_PIN_PULL_DN))
		else $error("pull active together with drive or other pull");
	reset_input_a: assert property (PIN_RESET |-> !RST_PIN_OE)
		else $error("pin reset while pin is driven");
	reset_cause_a: assert property ($rose(PIN_RESET)
		|-> $past(RST_PIN_I, 3))
		else $error("pin reset without high pin");
	pin_mid_a: assert property (PIN_RESET |=> TRACKED_CODE == 10'h200)
		else $error("tracked code not mid-scale after pin reset");
	start_mid_a: assert property ($rose(RESET_N)
		|-> TRACKED_CODE == 10'h200 && DAC_CODE == 10'h200)
		else $error("codes not mid-scale after reset");
	track_hold_a: assert property (no_update_s |=> $stable(TRACKED_CODE))
		else $error("tracked code moved without locked tick");
	dac_track_a: assert property (!HOLDOVER_ACTIVE
		|=> DAC_CODE == $past(TRACKED_CODE))
		else $error("dac code not following tracked code");
	auto_hold_a: assert property (AUTO_HOLD |=> HOLDOVER_ACTIVE)
		else $error("holdover not entered");
	loss_event_a: assert property ($rose(SIGNAL_LOSS)
		|-> CLK_SWITCH_EVT ##1 !CLK_SWITCH_EVT)
		else $error("switch event not a single pulse on loss");
	loss_mos_a: assert property (mos_off_s |=> !SIGNAL_LOSS)
		else $error("signal loss on non mos input");
endmodule

bind hdps_top hdps_top_chk hdps_top_chk_inst (
	.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
	.REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
	.RST_PIN_I(RST_PIN_I), .RST_PIN_OE(RST_PIN_OE),
	.RST_PIN_PULL_UP(RST_PIN_PULL_UP), .RST_PIN_PULL_DN(RST_PIN_PULL_DN),
	.PIN_RESET(PIN_RESET), .REF_IS_MOS(REF_IS_MOS),
	.SIGNAL_LOSS(SIGNAL_LOSS), .CLK_SWITCH_EVT(CLK_SWITCH_EVT),
	.FIRST_LOOP_LOCKED(FIRST_LOOP_LOCKED), .TRACK_TICK(TRACK_TICK),
	.AUTO_HOLD(AUTO_HOLD), .HOLDOVER_ACTIVE(HOLDOVER_ACTIVE),
	.TRACKED_CODE(TRACKED_CODE), .DAC_CODE(DAC_CODE));

`default_nettype wire

// ===== verification/hdps_top_tb_top.sv
// self-checking bench for the holdover dac and pin control top
`default_nettype none

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module hdps_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [2:0] io;
		logic [2:0] sel;
		logic       o;
		logic       oe;
		logic       pu;
		logic       pd;
	} hdps_row_s;
	hdps_row_s rows [17] = '{
		{3'h3, 3'h0, 4'h4}, {3'h3, 3'h1, 4'h4}, {3'h3, 3'h2, 4'hC},
		{3'h3, 3'h3, 4'h4}, {3'h3, 3'h4, 4'hC}, {3'h3, 3'h5, 4'h4},
		{3'h3, 3'h6, 4'hC}, {3'h3, 3'h7, 4'h4}, {3'h4, 3'h2, 4'h4},
		{3'h4, 3'h3, 4'hC}, {3'h6, 3'h3, 4'h4}, {3'h6, 3'h2, 4'h0},
		{3'h5, 3'h2, 4'h0}, {3'h7, 3'h2, 4'h0}, {3'h0, 3'h2, 4'h0},
		{3'h1, 3'h2, 4'h2}, {3'h2, 3'h6, 4'h1}};
	hdps_row_s r;
	int        checks = 0;
	int        fails = 0;
	logic       clk = 1'h0, rst_n = 1'h0, wr_s = 1'h0, rd_s = 1'h0;
	logic [8:0] addr = 9'h000;
	logic [7:0] wdata = 8'h00, rdata;
	logic       rvalid, pin_i, pin_o, pin_oe, pull_up, pull_dn, pin_rst;
	logic       drive_on = 1'h1, drive_val = 1'h0, ref_two = 1'h1;
	logic       locked = 1'h0, dac_low = 1'h1, dac_high = 1'h0;
	logic       rdbk = 1'h1, ref_clk = 1'h0, ref_mos = 1'h0, ref_run = 1'h0;
	logic       loss, sw_evt, loop_lk = 1'h0, tick = 1'h0, auto_hold = 1'h0;
	logic       hold;
	logic [9:0] tune = 10'h000, tracked, dac;

	always #20 clk = ~clk;
	always @(posedge clk) if (ref_run) ref_clk <= ~ref_clk;

	hdps_top hdps_top_inst (.CORE_CLK(clk), .RESET_N(rst_n),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s),
		.REG_RDATA(rdata), .REG_RVALID(rvalid), .RST_PIN_I(pin_i),
		.RST_PIN_O(pin_o), .RST_PIN_OE(pin_oe), .RST_PIN_PULL_UP(pull_up),
		.RST_PIN_PULL_DN(pull_dn), .PIN_RESET(pin_rst),
		.REF_TWO_SELECTED(ref_two), .DAC_LOCKED(locked), .DAC_LOW(dac_low),
		.DAC_HIGH(dac_high), .READBACK_DATA(rdbk), .REF_CLK_IN(ref_clk),
		.REF_IS_MOS(ref_mos), .SIGNAL_LOSS(loss), .CLK_SWITCH_EVT(sw_evt),
		.FIRST_LOOP_LOCKED(loop_lk), .TUNE_CODE(tune), .TRACK_TICK(tick),
		.AUTO_HOLD(auto_hold), .HOLDOVER_ACTIVE(hold),
		.TRACKED_CODE(tracked), .DAC_CODE(dac));

	hdps_pin_board hdps_pin_board_inst (.clk(clk), .pin_o(pin_o),
		.pin_oe(pin_oe), .pull_up(pull_up), .pull_dn(pull_dn),
		.drive_on(drive_on), .drive_val(drive_val), .pin_i(pin_i));

	// ------------------------------------------------------------
	// bus and timing helpers
	// ------------------------------------------------------------
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'h1;
		@(posedge clk);
		wr_s <= 1'h0;
	endtask

	task automatic rd(input logic [8:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'h1;
		@(posedge clk);
		rd_s <= 1'h0;
		@(negedge clk);
		`CHK("rvalid", 1'h1, rvalid)
		`CHK("rdata", e, rdata)
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic tk(input logic lk, input logic [9:0] t);
		@(posedge clk);
		loop_lk <= lk;
		tune <= t;
		tick <= 1'h1;
		@(posedge clk);
		tick <= 1'h0;
	endtask

	task automatic print_verdict();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		repeat (4000) @(posedge clk);
		fails++;
		print_verdict();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		@(negedge clk);
		`CHK("pull_dn", 1'h1, pull_dn)
		`CHK("oe", 1'h0, pin_oe)
		`CHK("tracked", 10'h200, tracked)
		`CHK("dac", 10'h200, dac)
		rd(9'h14A, 8'h02);
		rd(9'h14B, 8'h16);
		rd(9'h14C, 8'h00);
		rd(9'h149, 8'h00);
		for (int i = 0; i < 17; i++) begin
			r = rows[i];
			wr(9'h14A, {2'h3, r.sel, r.io});
			settle(3);
			`CHK("oe", r.oe, pin_oe)
			`CHK("pull_up", r.pu, pull_up)
			`CHK("pull_dn", r.pd, pull_dn)
			`CHK("pin_reset", 1'h0, pin_rst)
			if (r.oe)
				`CHK("pin_o", r.o, pin_o)
			rd(9'h14A, {2'h0, r.sel, r.io});
		end
		wr(9'h14A, 8'h02);
		wr(9'h14B, 8'h10);
		tk(1'h1, 10'h155);
		settle(3);
		`CHK("tracked", 10'h155, tracked)
		`CHK("dac", 10'h155, dac)
		tk(1'h0, 10'h2AA);
		wr(9'h14B, 8'h00);
		tk(1'h1, 10'h0AA);
		settle(3);
		`CHK("tracked", 10'h155, tracked)
		@(posedge clk);
		drive_val <= 1'h1;
		settle(6);
		`CHK("pin_reset", 1'h1, pin_rst)
		`CHK("tracked", 10'h200, tracked)
		@(posedge clk);
		drive_val <= 1'h0;
		settle(6);
		`CHK("pin_reset", 1'h0, pin_rst)
		wr(9'h14A, 8'h33);
		settle(3);
		wr(9'h14A, 8'h02);
		settle(2);
		`CHK("pin_reset", 1'h0, pin_rst)
		wr(9'h14C, 8'h34);
		wr(9'h14B, 8'h0E);
		settle(3);
		`CHK("hold", 1'h1, hold)
		`CHK("dac", 10'h234, dac)
		wr(9'h14B, 8'h0B);
		settle(3);
		`CHK("dac", 10'h200, dac)
		wr(9'h14B, 8'h07);
		wr(9'h14C, 8'hFF);
		settle(3);
		`CHK("hold", 1'h0, hold)
		`CHK("dac", 10'h200, dac)
		@(posedge clk);
		auto_hold <= 1'h1;
		settle(3);
		`CHK("dac", 10'h3FF, dac)
		@(posedge clk);
		auto_hold <= 1'h0;
		ref_run <= 1'h1;
		ref_mos <= 1'h1;
		wr(9'h14B, 8'hE0);
		settle(6);
		`CHK("loss", 1'h0, loss)
		@(posedge clk);
		ref_run <= 1'h0;
		settle(10);
		`CHK("loss", 1'h1, loss)
		@(posedge clk);
		ref_run <= 1'h1;
		settle(6);
		`CHK("loss", 1'h0, loss)
		wr(9'h14B, 8'h20);
		ref_run <= 1'h0;
		settle(60);
		`CHK("loss", 1'h0, loss)
		settle(16);
		`CHK("loss", 1'h1, loss)
		@(posedge clk);
		ref_mos <= 1'h0;
		settle(80);
		`CHK("loss", 1'h0, loss)
		wr(9'h14B, 8'hC0);
		ref_mos <= 1'h1;
		settle(10);
		`CHK("loss", 1'h0, loss)
		wr(9'h14B, 8'h10);
		tk(1'h1, 10'h3C3);
		rst_n <= 1'h0;
		settle(2);
		`CHK("tracked", 10'h200, tracked)
		@(posedge clk);
		rst_n <= 1'h1;
		rd(9'h14B, 8'h16);
		print_verdict();
	end
endmodule

`default_nettype wire
